/* File: rxirq_ctrl.v */
`timescale 1ns/1ps
`include "rxirq_map.vh"

module rxirq_ctrl (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // register port behind the serial host interface
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // receiver status flags and the first mask register
  input wire [7:0] rx_status,
  input wire [7:0] rx_src_mask,
  input wire output_slip_status,
  // pin function select
  input wire gpo_rx_irq_sel,
  // interrupt outputs
  output reg rx_irq,
  output reg gpo_irq_n
);

  // register state
  reg output_slip_mask_r;
  reg [7:0] mode_a_r;
  reg [7:0] mode_b_r;
  reg [7:0] rdata_nxt;

  // address decode
  wire sel_stat3;
  wire sel_mask2;
  wire sel_mode_a;
  wire sel_mode_b;
  wire wr_mask2;
  wire wr_mode_a;
  wire wr_mode_b;

  // read words, unused bits fill with zero
  wire [7:0] stat3_word;
  wire [7:0] mask2_word;

  // trigger field of each source
  wire [1:0] qsub_change_trigger;
  wire [1:0] lock_loss_trigger;
  wire [1:0] qsub_crc_trigger;
  wire [1:0] buffer_copy_trigger;
  wire [1:0] chan_stat_crc_trigger;
  wire [1:0] parity_err_trigger;
  wire [1:0] validity_err_trigger;
  wire [1:0] biphase_err_trigger;

  // detector hits before and after masking
  wire [7:0] src_hit;
  wire slip_hit;
  wire [7:0] src_live;
  wire slip_live;
  wire irq_nxt;
  wire pin_n_nxt;

  // address decode
  assign sel_stat3 = (reg_addr == `RXI_ADDR_STAT3);
  assign sel_mask2 = (reg_addr == `RXI_ADDR_MASK2);
  assign sel_mode_a = (reg_addr == `RXI_ADDR_MODE_A);
  assign sel_mode_b = (reg_addr == `RXI_ADDR_MODE_B);

  // the status address is read only, so it has no write strobe
  assign wr_mask2 = reg_wr & sel_mask2;
  assign wr_mode_a = reg_wr & sel_mode_a;
  assign wr_mode_b = reg_wr & sel_mode_b;

  // slip mask, only bit 0 is stored
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      output_slip_mask_r <= `RXI_RST_MASK2;
    end else if (wr_mask2) begin
      output_slip_mask_r <= reg_wdata[`RXI_BIT_SLIP_MASK];
    end
  end

  // mode register a
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_a_r <= `RXI_RST_MODE;
    end else if (wr_mode_a) begin
      mode_a_r <= reg_wdata;
    end
  end

  // mode register b
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_b_r <= `RXI_RST_MODE;
    end else if (wr_mode_b) begin
      mode_b_r <= reg_wdata;
    end
  end

  // readback words
  assign stat3_word = {`RXI_ZERO_HI, output_slip_status};
  assign mask2_word = {`RXI_ZERO_HI, output_slip_mask_r};

  // read mux; unmapped addresses read zero
  always @* begin
    if (sel_stat3) begin
      rdata_nxt = stat3_word;
    end else if (sel_mask2) begin
      rdata_nxt = mask2_word;
    end else if (sel_mode_a) begin
      rdata_nxt = mode_a_r;
    end else if (sel_mode_b) begin
      rdata_nxt = mode_b_r;
    end else begin
      rdata_nxt = `RXI_RST_RDATA;
    end
  end

  // read data register, holds until the next read strobe
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `RXI_RST_RDATA;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // mode register a fields
  assign qsub_change_trigger = mode_a_r[`RXI_FLD_HI];
  assign lock_loss_trigger = mode_a_r[`RXI_FLD_MH];
  assign qsub_crc_trigger = mode_a_r[`RXI_FLD_ML];
  assign buffer_copy_trigger = mode_a_r[`RXI_FLD_LO];

  // mode register b fields
  assign chan_stat_crc_trigger = mode_b_r[`RXI_FLD_HI];
  assign parity_err_trigger = mode_b_r[`RXI_FLD_MH];
  assign validity_err_trigger = mode_b_r[`RXI_FLD_ML];
  assign biphase_err_trigger = mode_b_r[`RXI_FLD_LO];

  // detectors for the mode register a sources
  rxirq_trig u_trig_qsub_change (
    .core_clk(core_clk),
    .rst(rst),
    .src(rx_status[`RXI_SRC_QCHG]),
    .mode(qsub_change_trigger),
    .hit(src_hit[`RXI_SRC_QCHG])
  );

  rxirq_trig u_trig_lock_loss (
    .core_clk(core_clk),
    .rst(rst),
    .src(rx_status[`RXI_SRC_LOCK]),
    .mode(lock_loss_trigger),
    .hit(src_hit[`RXI_SRC_LOCK])
  );

  rxirq_trig u_trig_qsub_crc (
    .core_clk(core_clk),
    .rst(rst),
    .src(rx_status[`RXI_SRC_QCRC]),
    .mode(qsub_crc_trigger),
    .hit(src_hit[`RXI_SRC_QCRC])
  );

  rxirq_trig u_trig_buffer_copy (
    .core_clk(core_clk),
    .rst(rst),
    .src(rx_status[`RXI_SRC_BUFCOPY]),
    .mode(buffer_copy_trigger),
    .hit(src_hit[`RXI_SRC_BUFCOPY])
  );

  // detectors for the mode register b sources
  rxirq_trig u_trig_chan_stat_crc (
    .core_clk(core_clk),
    .rst(rst),
    .src(rx_status[`RXI_SRC_CSCRC]),
    .mode(chan_stat_crc_trigger),
    .hit(src_hit[`RXI_SRC_CSCRC])
  );

  rxirq_trig u_trig_parity_err (
    .core_clk(core_clk),
    .rst(rst),
    .src(rx_status[`RXI_SRC_PARITY]),
    .mode(parity_err_trigger),
    .hit(src_hit[`RXI_SRC_PARITY])
  );

  rxirq_trig u_trig_validity_err (
    .core_clk(core_clk),
    .rst(rst),
    .src(rx_status[`RXI_SRC_VALID]),
    .mode(validity_err_trigger),
    .hit(src_hit[`RXI_SRC_VALID])
  );

  rxirq_trig u_trig_biphase_err (
    .core_clk(core_clk),
    .rst(rst),
    .src(rx_status[`RXI_SRC_BIPHASE]),
    .mode(biphase_err_trigger),
    .hit(src_hit[`RXI_SRC_BIPHASE])
  );

  // slip mode register lives elsewhere; slip uses the rising default
  // so a slip held high interrupts once, not on every cycle
  rxirq_trig u_slip (
    .core_clk(core_clk),
    .rst(rst),
    .src(output_slip_status),
    .mode(`RXI_MODE_RISE),
    .hit(slip_hit)
  );

  // only enabled sources reach the combined interrupt
  assign src_live = src_hit & rx_src_mask;
  assign slip_live = slip_hit & output_slip_mask_r;
  assign irq_nxt = (|src_live) | slip_live;
  assign pin_n_nxt = ~(irq_nxt & gpo_rx_irq_sel);

  // combined interrupt, one cycle behind the event
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_irq <= `RXI_RST_IRQ;
    end else begin
      rx_irq <= irq_nxt;
    end
  end

  // pin copy, low while active and selected, high otherwise
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gpo_irq_n <= `RXI_RST_PIN_N;
    end else begin
      gpo_irq_n <= pin_n_nxt;
    end
  end

endmodule // rxirq_ctrl

/* File: rxirq_ctrl_asserts.sv */
`timescale 1ns/1ps
module rxirq_ctrl_asserts (
  // clock and reset
  input logic core_clk,
  input logic rst,
  // register port
  input logic reg_wr,
  input logic reg_rd,
  input logic [6:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  // status and interrupts
  input logic [7:0] rx_status,
  input logic [7:0] rx_src_mask,
  input logic output_slip_status,
  input logic gpo_rx_irq_sel,
  input logic rx_irq,
  input logic gpo_irq_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_pin_follow: assert property (gpo_irq_n == !(rx_irq && $past(gpo_rx_irq_sel)))
    else $error("pin level wrong");
  a_mask_gate: assert property (!rx_src_mask && !output_slip_status |=> !rx_irq)
    else $error("masked irq");
  a_quiet_src: assert property (!rx_status && $stable(rx_status)
    && !output_slip_status |=> !rx_irq)
    else $error("irq without event");
  a_slip_read: assert property (reg_rd && reg_addr == 7'h0F
    |=> reg_rdata == {7'h00, $past(output_slip_status)})
    else $error("slip read wrong");
  a_mask_high: assert property (reg_rd && reg_addr == 7'h17 |=> !reg_rdata[7:1])
    else $error("mask high bits");
  a_unmapped_zero: assert property (reg_rd
    && !(reg_addr inside {7'h0F, 7'h17, 7'h18, 7'h19}) |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("rdata moved");
  a_mode_back: assert property (reg_wr && !reg_rd && reg_addr[6:1] == 6'h0C
    ##1 reg_rd && !reg_wr && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("mode readback");
  c_irq: cover property ($rose(rx_irq));
  c_pin: cover property (!gpo_irq_n);
  c_back: cover property (reg_wr ##1 reg_rd);
endmodule // rxirq_ctrl_asserts

/* File: rxirq_ctrl_tb_top.sv */
`timescale 1ns/1ps
module rxirq_ctrl_tb_top;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, slip = 0, sel = 1;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00, st = 8'h00, msk = 8'h00;
  wire [7:0] reg_rdata;
  wire rx_irq, gpo_irq_n;
  int failures = 0, check_count = 0, cyc = 0;
  // address, mode value, mask, status before, status after, irq expected
  logic [43:0] rows [12] = '{44'h18000800081, 44'h18400808001, 44'h18400800080,
    44'h18200404041, 44'h18080202021, 44'h18C00800080, 44'h19808080801,
    44'h19082020201, 44'h19080020200, 44'h18000100011, 44'h19104040001,
    44'h19021010101};
  rxirq_ctrl DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_status(st),
    .rx_src_mask(msk), .output_slip_status(slip), .gpo_rx_irq_sel(sel), .rx_irq(rx_irq),
    .gpo_irq_n(gpo_irq_n));
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc > 900) begin
    failures++;
    finish_test();
  end
  task finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // write then read back on the next cycle, or read alone
  task rw(input [6:0] a, input [7:0] d, input w, input [7:0] e);
    @(negedge core_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, w};
    @(negedge core_clk) {reg_wr, reg_rd} = 2'b01;
    @(negedge core_clk) reg_rd = 0;
    chk(reg_rdata, e);
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    rst = 0;
    foreach (rows[i]) begin
      rw(rows[i][42:36], rows[i][35:28], 1, rows[i][35:28]);
      msk = rows[i][27:20];
      @(negedge core_clk) st = rows[i][19:12];
      @(negedge core_clk) st = rows[i][11:4];
      @(negedge core_clk);
      chk(rx_irq, rows[i][0]);
      chk(gpo_irq_n, !rows[i][0]);
      $display("row %0d done", i);
    end
    rw(7'h17, 8'hFF, 1, 8'h01);
    {msk, st, sel, slip} = 18'h00001;
    @(negedge core_clk) chk(rx_irq, 8'h01);
    chk(gpo_irq_n, 8'h01);
    @(negedge core_clk) chk(rx_irq, 8'h00);
    rw(7'h05, 8'h5A, 1, 8'h00);
    rw(7'h0F, 8'h00, 0, 8'h01);
    // qsub change in level mode holds the interrupt up into the reset
    rw(7'h18, 8'h80, 1, 8'h80);
    {msk, st, sel} = 17'h01011;
    @(negedge core_clk) chk(rx_irq, 8'h01);
    chk(gpo_irq_n, 8'h00);
    rst = 1;
    @(negedge core_clk) chk(rx_irq, 8'h00);
    chk(gpo_irq_n, 8'h01);
    chk(reg_rdata, 8'h00);
    rst = 0;
    // status already high at release gives one rising hit, then none
    @(negedge core_clk) chk(rx_irq, 8'h01);
    @(negedge core_clk) chk(rx_irq, 8'h00);
    rw(7'h17, 8'h00, 0, 8'h00);
    chk(rx_irq, 8'h00);
    rw(7'h18, 8'h00, 0, 8'h00);
    rw(7'h19, 8'h00, 0, 8'h00);
    $display("hand tests done");
    finish_test();
  end
endmodule // rxirq_ctrl_tb_top
bind rxirq_ctrl rxirq_ctrl_asserts u_chk (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .rx_status(rx_status), .rx_src_mask(rx_src_mask), .output_slip_status(output_slip_status),
  .gpo_rx_irq_sel(gpo_rx_irq_sel), .rx_irq(rx_irq), .gpo_irq_n(gpo_irq_n));

/* File: rxirq_map.vh */
`ifndef RXIRQ_MAP_VH
`define RXIRQ_MAP_VH

// register addresses on the host port
`define RXI_ADDR_W 7
`define RXI_ADDR_STAT3 7'h0F
`define RXI_ADDR_MASK2 7'h17
`define RXI_ADDR_MODE_A 7'h18
`define RXI_ADDR_MODE_B 7'h19

// reset values
`define RXI_RST_MASK2 1'b0
`define RXI_RST_MODE 8'h00
`define RXI_RST_RDATA 8'h00
`define RXI_RST_IRQ 1'b0
`define RXI_RST_PIN_N 1'b1
`define RXI_RST_PREV 1'b0

// slip mask bit and the zero fill above it
`define RXI_BIT_SLIP_MASK 0
`define RXI_ZERO_HI 7'h00

// trigger mode encodings
`define RXI_MODE_RISE 2'b00
`define RXI_MODE_FALL 2'b01
`define RXI_MODE_LEVEL 2'b10
`define RXI_MODE_RSVD 2'b11

// source index, same order as the first mask register
`define RXI_SRC_BUFCOPY 0
`define RXI_SRC_QCRC 1
`define RXI_SRC_LOCK 2
`define RXI_SRC_QCHG 3
`define RXI_SRC_BIPHASE 4
`define RXI_SRC_VALID 5
`define RXI_SRC_PARITY 6
`define RXI_SRC_CSCRC 7
`define RXI_NSRC 8

// field positions in mode registers
`define RXI_FLD_HI 7:6
`define RXI_FLD_MH 5:4
`define RXI_FLD_ML 3:2
`define RXI_FLD_LO 1:0

`endif

/* File: rxirq_trig.v */
`timescale 1ns/1ps
`include "rxirq_map.vh"

module rxirq_trig (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // source and mode
  input wire src,
  input wire [1:0] mode,
  // event indication
  output reg hit
);

  reg prev_r;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_r <= `RXI_RST_PREV;
    end else begin
      prev_r <= src;
    end
  end

  always @* begin
    case (mode)
      `RXI_MODE_RISE: hit = src & ~prev_r;
      `RXI_MODE_FALL: hit = ~src & prev_r;
      `RXI_MODE_LEVEL: hit = src;
      default: hit = 1'b0;
    endcase
  end

endmodule // rxirq_trig
